// ---- gpx_board_model.sv ----
// Board-side pad model resolving each pad from the block's driver and an outside source.
`timescale 1ns/100ps
module gpx_board_model
  import gpx_pkg::*;
(
  input wire logic [NUM_PORTS*PW-1:0] pad_out_i,
  input wire logic [NUM_PORTS*PW-1:0] pad_oe_i,
  input wire logic [NUM_PORTS*PW-1:0] ext_i,
  output logic [NUM_PORTS*PW-1:0] pad_in_o
);
  // ====
  // Pad resolution
  // A driven pad shows the driven level, so a pin stays readable whoever owns it.
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

// ---- gpx_pkg.sv ----
// Package of register map, field layouts and reset values for the parallel port block.
package gpx_pkg;

  // ==========================================================================
  // Sizes
  localparam int PW = 16;
  localparam int NUM_PORTS = 5;
  localparam int IDX_W = 10;
  localparam int HADDR_W = 12;
  localparam int ADDR_LSB = 2;
  localparam int HDATA_W = 32;
  localparam int CN_NUM = 24;
  localparam int CN_REG_W = 16;
  localparam int CN_HI_W = CN_NUM - CN_REG_W;
  localparam int IRQ_W = 1;

  // ==========================================================================
  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CN_EN_LO = 10'h0C0;
  localparam logic [IDX_W-1:0] IDX_CN_EN_HI = 10'h0C2;
  localparam logic [IDX_W-1:0] IDX_CN_PU_LO = 10'h0C4;
  localparam logic [IDX_W-1:0] IDX_CN_PU_HI = 10'h0C6;
  localparam logic [IDX_W-1:0] IDX_ANALOG_SEL = 10'h300;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h302;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h304;

  // Port order: A, B, C, D, F.
  localparam logic [IDX_W-1:0] IDX_DIR [NUM_PORTS] = '{10'h2C0, 10'h2C6, 10'h2CC, 10'h2D2, 10'h2DE};
  localparam logic [IDX_W-1:0] IDX_LVL [NUM_PORTS] = '{10'h2C2, 10'h2C8, 10'h2CE, 10'h2D4, 10'h2E0};
  localparam logic [IDX_W-1:0] IDX_LAT [NUM_PORTS] = '{10'h2C4, 10'h2CB, 10'h2D0, 10'h2D6, 10'h2E2};

  // ==========================================================================
  // Implemented bits, which are also the direction reset values
  localparam logic [PW-1:0] PORT_MASK [NUM_PORTS] = '{16'h0800, 16'h1FFF, 16'hE000, 16'h030F,
                                                      16'h007F};
  localparam logic [NUM_PORTS-1:0] PORT_SHARED = 5'h1E;
  localparam int ANALOG_PORT = 1;
  localparam logic [PW-1:0] RST_ZERO = 16'h0000;
  localparam int IRQ_CN_BIT = 0;

  // ==========================================================================
  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

endpackage

// ---- gpx_port.sv ----
// One parallel port slice: direction, latch, pad ownership and pin sampling.
`timescale 1ns/100ps
module gpx_port
  import gpx_pkg::*;
#(
  parameter logic [PW-1:0] MASK = 16'hFFFF,
  parameter logic SHARED = 1'h1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  gpx_port_if.port bus,
  input wire logic [PW-1:0] pad_in_i,
  input wire logic [PW-1:0] periph_drive_i,
  input wire logic [PW-1:0] periph_out_i,
  output logic [PW-1:0] pad_out_o,
  output logic [PW-1:0] pad_oe_o
);

  logic [PW-1:0] dir_reg;
  logic [PW-1:0] lat_reg;
  logic [PW-1:0] sync1_reg;
  logic [PW-1:0] sync2_reg;
  logic [PW-1:0] pad_out_reg;
  logic [PW-1:0] pad_oe_reg;
  wire [PW-1:0] periph_own;
  wire [PW-1:0] port_oe;
  wire [PW-1:0] out_next;
  wire [PW-1:0] oe_next;

  // ==========================================================================
  // Pad ownership
  // An input-only partner never competes for the driver, so the slice keeps it.
  assign periph_own = SHARED ? (periph_drive_i & MASK) : RST_ZERO;
  // Cleared direction keeps the driver on even on an analog pin.
  assign port_oe = ~dir_reg & MASK;
  assign out_next = (periph_own & periph_out_i) | (~periph_own & lat_reg);
  assign oe_next = periph_own | (~periph_own & port_oe);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dir_reg <= MASK;
      lat_reg <= RST_ZERO;
      sync1_reg <= RST_ZERO;
      sync2_reg <= RST_ZERO;
      pad_out_reg <= RST_ZERO;
      pad_oe_reg <= RST_ZERO;
    end else begin
      if (bus.wr_dir) begin
        dir_reg <= bus.wdata & MASK;
      end
      if (bus.wr_lat) begin
        lat_reg <= bus.wdata & MASK;
      end
      sync1_reg <= pad_in_i;
      sync2_reg <= sync1_reg;
      pad_out_reg <= out_next;
      pad_oe_reg <= oe_next;
    end
  end

  // ==========================================================================
  // Read-back
  // The pin stays readable while a peripheral owns the driver.
  assign bus.dir = dir_reg;
  assign bus.lat = lat_reg;
  assign bus.level = sync2_reg & MASK & ~bus.analog_sel;
  assign pad_out_o = pad_out_reg;
  assign pad_oe_o = pad_oe_reg;

endmodule

// ---- gpx_port_if.sv ----
// Interface carrying register access between the top and one port slice.
`timescale 1ns/100ps
interface gpx_port_if;
  import gpx_pkg::*;
  logic [PW-1:0] wdata;
  logic wr_dir;
  logic wr_lat;
  logic [PW-1:0] analog_sel;
  logic [PW-1:0] dir;
  logic [PW-1:0] lat;
  logic [PW-1:0] level;
  modport ctrl (output wdata, output wr_dir, output wr_lat, output analog_sel,
                input dir, input lat, input level);
  modport port (input wdata, input wr_dir, input wr_lat, input analog_sel,
                output dir, output lat, output level);
endinterface

// ---- gpx_top.sv ----
// Top of the parallel port block with change notification and AHB-Lite register slave.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps

module gpx_top
  import gpx_pkg::*;
#(
  parameter int NPORT = NUM_PORTS,
  parameter int NCN = CN_NUM
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [HADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [HDATA_W-1:0] hwdata_i,
  input wire logic hready_i,
  output logic [HDATA_W-1:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [NPORT*PW-1:0] pad_in_i,
  input wire logic [NPORT*PW-1:0] periph_drive_i,
  input wire logic [NPORT*PW-1:0] periph_out_i,
  output logic [NPORT*PW-1:0] pad_out_o,
  output logic [NPORT*PW-1:0] pad_oe_o,
  input wire logic [NCN-1:0] change_notify_inputs_i,
  output logic [NCN-1:0] change_notify_pullup_o,
  output logic [PW-1:0] analog_convert_o,
  output logic irq_o
);

  // ==========================================================================
  // Bus slave state
  logic wr_pend_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [HDATA_W-1:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;

  // ==========================================================================
  // Software registers
  logic [CN_REG_W-1:0] cn_en_lo_reg;
  logic [CN_HI_W-1:0] cn_en_hi_reg;
  logic [CN_REG_W-1:0] cn_pu_lo_reg;
  logic [CN_HI_W-1:0] cn_pu_hi_reg;
  logic [PW-1:0] analog_sel_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;
  logic [NCN-1:0] pullup_reg;
  logic [PW-1:0] analog_conv_reg;

  // ==========================================================================
  // Change detection state
  logic [NCN-1:0] cn_sync1_reg;
  logic [NCN-1:0] cn_sync2_reg;
  logic [NCN-1:0] cn_prev_reg;
  logic cn_primed_reg;

  // ==========================================================================
  // Address and data phase decode
  wire addr_phase;
  wire rd_phase;
  wire [IDX_W-1:0] ap_idx;
  wire [PW-1:0] wdata16;
  wire wr_cn_en_lo;
  wire wr_cn_en_hi;
  wire wr_cn_pu_lo;
  wire wr_cn_pu_hi;
  wire wr_analog_sel;
  wire wr_irq_mask;
  wire rd_irq_status;

  assign addr_phase = hsel_i & htrans_i[1] & hready_i & (hsize_i == HSIZE_WORD);
  assign rd_phase = addr_phase & ~hwrite_i;
  assign ap_idx = haddr_i[HADDR_W-1:ADDR_LSB];
  assign wdata16 = hwdata_i[PW-1:0];
  assign wr_cn_en_lo = wr_pend_reg & (wr_idx_reg == IDX_CN_EN_LO);
  assign wr_cn_en_hi = wr_pend_reg & (wr_idx_reg == IDX_CN_EN_HI);
  assign wr_cn_pu_lo = wr_pend_reg & (wr_idx_reg == IDX_CN_PU_LO);
  assign wr_cn_pu_hi = wr_pend_reg & (wr_idx_reg == IDX_CN_PU_HI);
  assign wr_analog_sel = wr_pend_reg & (wr_idx_reg == IDX_ANALOG_SEL);
  assign wr_irq_mask = wr_pend_reg & (wr_idx_reg == IDX_IRQ_MASK);
  assign rd_irq_status = rd_phase & (ap_idx == IDX_IRQ_STATUS);

  // ==========================================================================
  // Port slices
  logic [PW-1:0] port_dir [NPORT];
  logic [PW-1:0] port_lat [NPORT];
  logic [PW-1:0] port_lvl [NPORT];

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    gpx_port_if pif ();
    // Software must leave three idle cycles before reading the pins back, since the
    // latch passes the pad output register and then two sampling flip-flops.
    assign pif.wdata = wdata16;
    assign pif.wr_dir = wr_pend_reg & (wr_idx_reg == IDX_DIR[p]);
    // Both the latch and the pin-level offsets write the latch.
    assign pif.wr_lat = wr_pend_reg & ((wr_idx_reg == IDX_LAT[p]) |
                                       (wr_idx_reg == IDX_LVL[p]));
    // Only the port carrying analog inputs sees the analog select.
    assign pif.analog_sel = (p == ANALOG_PORT) ? analog_sel_reg : RST_ZERO;
    assign port_dir[p] = pif.dir;
    assign port_lat[p] = pif.lat;
    assign port_lvl[p] = pif.level;

    gpx_port #(
      .MASK(PORT_MASK[p]),
      .SHARED(PORT_SHARED[p])
    ) u_port (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .bus(pif),
      .pad_in_i(pad_in_i[p*PW +: PW]),
      .periph_drive_i(periph_drive_i[p*PW +: PW]),
      .periph_out_i(periph_out_i[p*PW +: PW]),
      .pad_out_o(pad_out_o[p*PW +: PW]),
      .pad_oe_o(pad_oe_o[p*PW +: PW])
    );
  end

  // ==========================================================================
  // Read data selection
  logic [PW-1:0] rd_word;

  always_comb begin
    rd_word = RST_ZERO;
    for (int p = 0; p < NPORT; p++) begin
      if (ap_idx == IDX_DIR[p]) begin
        rd_word = port_dir[p];
      end
      if (ap_idx == IDX_LVL[p]) begin
        rd_word = port_lvl[p];
      end
      if (ap_idx == IDX_LAT[p]) begin
        rd_word = port_lat[p];
      end
    end
    case (ap_idx)
      IDX_CN_EN_LO: rd_word = cn_en_lo_reg;
      IDX_CN_EN_HI: rd_word = PW'(cn_en_hi_reg);
      IDX_CN_PU_LO: rd_word = cn_pu_lo_reg;
      IDX_CN_PU_HI: rd_word = PW'(cn_pu_hi_reg);
      IDX_ANALOG_SEL: rd_word = analog_sel_reg;
      IDX_IRQ_STATUS: rd_word = PW'(irq_status_reg);
      IDX_IRQ_MASK: rd_word = PW'(irq_mask_reg);
      default: rd_word = rd_word;
    endcase
  end

  // ==========================================================================
  // Bus slave
  // Zero wait states: read data is registered in the address phase, so it
  // stands for the whole data phase; writes land at the end of the data phase.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_pend_reg <= 1'h0;
      wr_idx_reg <= '0;
      hrdata_reg <= '0;
      hreadyout_reg <= 1'h1;
      hresp_reg <= HRESP_OKAY;
    end else begin
      wr_pend_reg <= addr_phase & hwrite_i;
      if (addr_phase) begin
        wr_idx_reg <= ap_idx;
      end
      if (rd_phase) begin
        hrdata_reg <= HDATA_W'(rd_word);
      end
      hreadyout_reg <= 1'h1;
      hresp_reg <= HRESP_OKAY;
    end
  end

  // ==========================================================================
  // Change notification and analog configuration registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cn_en_lo_reg <= '0;
      cn_en_hi_reg <= '0;
      cn_pu_lo_reg <= '0;
      cn_pu_hi_reg <= '0;
      analog_sel_reg <= RST_ZERO;
      irq_mask_reg <= '0;
      pullup_reg <= '0;
      analog_conv_reg <= RST_ZERO;
    end else begin
      if (wr_cn_en_lo) begin
        cn_en_lo_reg <= wdata16;
      end
      if (wr_cn_en_hi) begin
        cn_en_hi_reg <= wdata16[CN_HI_W-1:0];
      end
      if (wr_cn_pu_lo) begin
        cn_pu_lo_reg <= wdata16;
      end
      if (wr_cn_pu_hi) begin
        cn_pu_hi_reg <= wdata16[CN_HI_W-1:0];
      end
      if (wr_analog_sel) begin
        analog_sel_reg <= wdata16 & PORT_MASK[ANALOG_PORT];
      end
      if (wr_irq_mask) begin
        irq_mask_reg <= wdata16[IRQ_W-1:0];
      end
      pullup_reg <= {cn_pu_hi_reg, cn_pu_lo_reg};
      // Only analog-selected pins are offered to the converter; a digital
      // input is never converted, whatever its direction.
      analog_conv_reg <= analog_sel_reg;
    end
  end

  // ==========================================================================
  // Change detection
  wire [NCN-1:0] cn_enable;
  wire cn_change;

  assign cn_enable = {cn_en_hi_reg, cn_en_lo_reg};
  // The primed flag masks only the first cycle after reset, when cn_sync2_reg and the
  // reference are both still zero; a pin high out of reset still differs once it reaches cn_sync2_reg.
  assign cn_change = cn_primed_reg & (|((cn_sync2_reg ^ cn_prev_reg) & cn_enable));

  // While the clock is stopped the reference holds the level seen before, so
  // a pin that moves in that time differs once it reaches cn_sync2_reg, at the second edge after restart.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cn_sync1_reg <= '0;
      cn_sync2_reg <= '0;
      cn_prev_reg <= '0;
      cn_primed_reg <= 1'h0;
    end else begin
      cn_sync1_reg <= change_notify_inputs_i;
      cn_sync2_reg <= cn_sync1_reg;
      cn_prev_reg <= cn_sync2_reg;
      cn_primed_reg <= 1'h1;
    end
  end

  // ==========================================================================
  // Interrupt status, cleared by a read; a change in the clearing cycle wins.
  always_comb begin
    irq_status_next = irq_status_reg;
    if (rd_irq_status) begin
      irq_status_next = '0;
    end
    if (cn_change) begin
      irq_status_next[IRQ_CN_BIT] = 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_status_reg <= '0;
      irq_reg <= 1'h0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ==========================================================================
  // Outputs
  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;
  assign change_notify_pullup_o = pullup_reg;
  assign analog_convert_o = analog_conv_reg;
  assign irq_o = irq_reg;

endmodule

// ---- gpx_top_chk.sv ----
// Checker of pad ownership, reset state, read-back masking and interrupt hold.
`timescale 1ns/100ps
module gpx_top_chk
  import gpx_pkg::*;
#(
  parameter int NPORT = NUM_PORTS,
  parameter int NCN = CN_NUM
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [HADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [HDATA_W-1:0] hrdata_o,
  input wire logic [NPORT*PW-1:0] periph_drive_i,
  input wire logic [NPORT*PW-1:0] periph_out_i,
  input wire logic [NPORT*PW-1:0] pad_out_o,
  input wire logic [NPORT*PW-1:0] pad_oe_o,
  input wire logic [NCN-1:0] change_notify_pullup_o,
  input wire logic [PW-1:0] analog_convert_o,
  input wire logic irq_o
);
  // ====
  // Decode
  localparam logic [NPORT*PW-1:0] IMPL = {PORT_MASK[4], PORT_MASK[3], PORT_MASK[2],
    PORT_MASK[1], PORT_MASK[0]};
  wire logic taken = hsel_i & htrans_i[1] & hready_i & (hsize_i == HSIZE_WORD);
  wire logic rd_any = taken & ~hwrite_i;
  wire logic rd_blvl = rd_any & (haddr_i == {IDX_LVL[1], 2'b00});
  wire logic rd_dport = rd_any & (haddr_i[11:2] inside {IDX_DIR[3], IDX_LVL[3], IDX_LAT[3]});
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ====
  // Properties
  // Three idle bus cycles, so that no register write lands inside the checked window.
  sequence s_quiet;
    !taken ##1 !taken ##1 !taken;
  endsequence
  property p_reset_pads;
    $fell(reset_i) |-> pad_oe_o == '0;
  endproperty
  a_reset_pads: assert property (p_reset_pads) else $error("pad driver on after reset");
  property p_reset_pullup;
    $fell(reset_i) |-> change_notify_pullup_o == '0 && !irq_o;
  endproperty
  a_reset_pullup: assert property (p_reset_pullup) else $error("pull-up set after reset");
  property p_periph_owns;
    periph_drive_i[16] |=> pad_oe_o[16] && pad_out_o[16] == $past(periph_out_i[16]);
  endproperty
  a_periph_owns: assert property (p_periph_owns) else $error("peripheral lost the pad");
  property p_port_owns;
    (s_quiet ##0 !periph_drive_i[16] && !$past(periph_drive_i[16]))
      |=> $stable(pad_out_o[16]) && $stable(pad_oe_o[16]);
  endproperty
  a_port_owns: assert property (p_port_owns) else $error("port pad moved by peripheral");
  property p_unimpl_oe;
    (pad_oe_o & ~IMPL) == '0;
  endproperty
  a_unimpl_oe: assert property (p_unimpl_oe) else $error("unimplemented pad driven");
  property p_unimpl_read;
    rd_dport |=> (hrdata_o & ~{16'h0000, PORT_MASK[3]}) == '0;
  endproperty
  a_unimpl_read: assert property (p_unimpl_read) else $error("unimplemented bit read one");
  property p_analog_zero;
    rd_blvl |=> (hrdata_o[PW-1:0] & analog_convert_o & $past(analog_convert_o)) == '0;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read one");
  property p_irq_hold;
    (s_quiet ##0 irq_o) |=> irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped unread");
endmodule

bind gpx_top gpx_top_chk #(.NPORT(NPORT), .NCN(NCN)) u_chk (.clk_i, .reset_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hready_i, .hrdata_o, .periph_drive_i,
  .periph_out_i, .pad_out_o, .pad_oe_o, .change_notify_pullup_o, .analog_convert_o, .irq_o);

// ---- tb_gpio_ports_with_change_notify.sv ----
// Self-checking bench of the parallel port block with board model and checker.
`timescale 1ns/100ps
module tb_gpio_ports_with_change_notify;
  import gpx_pkg::*;
  logic clk_i = 0, clk_run = 1, reset_i = 1, hsel_i = 0, hwrite_i = 0;
  logic hreadyout_o, hresp_o, irq_o, hready_i;
  logic [HADDR_W-1:0] haddr_i = '0;
  logic [1:0] htrans_i = '0;
  logic [2:0] hsize_i = HSIZE_WORD;
  logic [HDATA_W-1:0] hwdata_i = '0, hrdata_o, rd;
  logic [NUM_PORTS*PW-1:0] pad_in_i, pad_out_o, pad_oe_o, periph_drive_i = '0;
  logic [NUM_PORTS*PW-1:0] periph_out_i = '0, ext = '0;
  logic [CN_NUM-1:0] change_notify_inputs_i = '0, change_notify_pullup_o, en;
  logic [PW-1:0] analog_convert_o, v;
  logic [PW-1:0] lat_e [NUM_PORTS];
  int seed = 17, miscompares = 0, num_checks = 0, cycles = 0, p, k;
  assign hready_i = hreadyout_o;
  // Stopping the clock stands in for sleep; change detection must survive it.
  always #50 if (clk_run) clk_i = ~clk_i;
  gpx_top DUT (.clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .pad_in_i, .periph_drive_i,
    .periph_out_i, .pad_out_o, .pad_oe_o, .change_notify_inputs_i, .change_notify_pullup_o,
    .analog_convert_o, .irq_o);
  gpx_board_model u_board (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_i(ext),
    .pad_in_o(pad_in_i));
  // ====
  // Tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {idx, 2'b00};
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, '0);
    chk(rd, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wait_irq();
    for (int w = 0; w < 10 && irq_o !== 1'b1; w++) @(posedge clk_i);
  endtask
  function automatic logic [31:0] impl(input int q, input logic [PW-1:0] d);
    return {16'h0000, d & PORT_MASK[q]};
  endfunction
  // ====
  // Scenarios
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    for (p = 0; p < NUM_PORTS; p++) begin
      rchk(IDX_DIR[p], impl(p, 16'hFFFF));
      rchk(IDX_LAT[p], '0);
      rchk(IDX_LVL[p], '0);
    end
    for (k = 0; k < 4; k++) rchk(IDX_W'(IDX_CN_EN_LO + 2 * k), '0);
    chk(hresp_o, HRESP_OKAY);
    $display("test done: reset values");
    for (p = 0; p < NUM_PORTS; p++) begin
      v = 16'($random(seed));
      wr(IDX_LVL[p], {16'hFFFF, v});
      rchk(IDX_LAT[p], impl(p, v));
      v = 16'($random(seed));
      lat_e[p] = v;
      wr(IDX_LAT[p], {16'h0000, v});
      wr(IDX_DIR[p], '0);
      rchk(IDX_LAT[p], impl(p, v));
      idle(5);
      rchk(IDX_LVL[p], impl(p, v));
      chk(pad_oe_o[p*PW +: PW], impl(p, 16'hFFFF));
      wr(IDX_DIR[p], 32'h0000FFFF);
      ext[p*PW +: PW] <= 16'($random(seed));
      idle(5);
      rchk(IDX_LVL[p], impl(p, ext[p*PW +: PW]));
      chk(pad_oe_o[p*PW +: PW], '0);
    end
    $display("test done: latch, pins and direction");
    periph_drive_i <= '1;
    periph_out_i <= {$random(seed), $random(seed), 16'($random(seed))};
    for (p = 0; p < NUM_PORTS; p++) wr(IDX_DIR[p], '0);
    idle(5);
    for (p = 0; p < NUM_PORTS; p++) begin
      v = (p == 0) ? lat_e[0] : periph_out_i[p*PW +: PW];
      chk(impl(p, pad_out_o[p*PW +: PW]), impl(p, v));
      chk(pad_oe_o[p*PW +: PW], impl(p, 16'hFFFF));
      rchk(IDX_LVL[p], impl(p, v));
    end
    periph_drive_i <= '0;
    idle(3);
    for (p = 1; p < NUM_PORTS; p++) chk(impl(p, pad_out_o[p*PW +: PW]), impl(p, lat_e[p]));
    $display("test done: pad ownership");
    v = 16'($random(seed));
    wr(IDX_ANALOG_SEL, {16'h0000, v});
    wr(IDX_DIR[1], 32'h0000FFFF);
    ext[PW +: PW] <= 16'($random(seed));
    idle(5);
    rchk(IDX_LVL[1], impl(1, ext[PW +: PW] & ~v));
    chk(analog_convert_o, v & PORT_MASK[1]);
    wr(IDX_DIR[1], '0);
    idle(3);
    chk(pad_oe_o[PW +: PW], PORT_MASK[1]);
    wr(IDX_ANALOG_SEL, '0);
    $display("test done: analog pins");
    wr(IDX_IRQ_MASK, 32'h1);
    for (k = 0; k < CN_NUM; k++) begin
      en = 24'h1 << k;
      wr(IDX_CN_EN_LO, {16'h0000, en[15:0]});
      wr(IDX_CN_EN_HI, {24'h0, en[23:16]});
      rchk(IDX_IRQ_STATUS, '0);
      change_notify_inputs_i[(k + 1) % CN_NUM] <= ~change_notify_inputs_i[(k + 1) % CN_NUM];
      idle(6);
      chk(irq_o, 1'b0);
      change_notify_inputs_i[k] <= ~change_notify_inputs_i[k];
      wait_irq();
      chk(irq_o, 1'b1);
      rchk(IDX_IRQ_STATUS, 32'h1);
      idle(2);
      chk(irq_o, 1'b0);
    end
    wr(IDX_IRQ_MASK, '0);
    change_notify_inputs_i[23] <= ~change_notify_inputs_i[23];
    idle(6);
    chk(irq_o, 1'b0);
    rchk(IDX_IRQ_STATUS, 32'h1);
    wr(IDX_IRQ_MASK, 32'h1);
    clk_run = 1'b0;
    #1000 change_notify_inputs_i[23] = ~change_notify_inputs_i[23];
    #1000 clk_run = 1'b1;
    wait_irq();
    chk(irq_o, 1'b1);
    rchk(IDX_IRQ_STATUS, 32'h1);
    $display("test done: change notification");
    v = 16'($random(seed));
    wr(IDX_CN_PU_LO, {16'h0000, v});
    wr(IDX_CN_PU_HI, 32'h0000FFFF);
    idle(2);
    chk(change_notify_pullup_o, {8'hFF, v});
    rchk(IDX_CN_PU_HI, 32'h000000FF);
    wr(10'h3FF, '1);
    rchk(10'h3FF, '0);
    $display("test done: pull-ups and unmapped");
    print_verdict();
  end
endmodule
